//--- src/adc_conversion_sequencer.sv
// apb-controlled sequencer of a 10-bit successive-approximation converter
//
// How it works
// - the converter is powered only while adc_enable is one
// - writing one to convert_go_busy starts a conversion on the selected channel
// - completion clears busy, sets done flag and loads the result pair
// - clearing busy early stops conversion and keeps the previous result
// - after a busy clear in conversion wait two bit periods, then acquisition resumes; a clear in the rc start delay returns at once
// - reset restores registers, powers off and ends any conversion
// - with internal rc clock the start is delayed one instruction cycle
// - in sleep with rc clock, wake on done if irq enabled, else shut off
// - other clocks: sleep aborts and powers off, adc_enable stays set
// - the special event trigger sets busy and resets timer one
// - control bit 7 selects right (1) or left (0) justification
// - control bit 6 selects the reference; bit 5 reads zero
// - control bits 4 to 2 select the input channel; 111 reserved
// - busy bit 1 reads one during conversion, hardware clears it
// - left justified: high holds bits 9..2, low bits 7..6 hold 1..0
// - right justified: high bits 1..0 hold 9..8, low holds 7..0
// - a full conversion takes eleven bit periods
// - clock select codes give /2../64 and x11 the internal rc clock
// - done flag is set on every completed conversion and cleared only by software or reset
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_conversion_sequencer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] sampleCode,
  input wire logic specialEvent,
  input wire logic sleepActive,
  input wire logic irqEnable,
  output logic converterPowered,
  output logic [2:0] channelSelect,
  output logic referenceSelect,
  output logic acquiring,
  output logic timerOneReset,
  output logic wakeRequest,
  output logic doneFlag
);
  import adc_seq_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  adc_seq_pkg::byte_t control;
  adc_seq_pkg::byte_t next_control;
  adc_seq_pkg::byte_t resultHigh;
  adc_seq_pkg::byte_t next_resultHigh;
  adc_seq_pkg::byte_t resultLow;
  adc_seq_pkg::byte_t next_resultLow;
  logic [2:0] clockSel;
  logic [2:0] next_clockSel;
  logic next_doneFlag;
  logic sleepOff;
  logic next_sleepOff;
  seq_state_t state;
  seq_state_t next_state;
  logic [3:0] tadCount;
  logic [3:0] next_tadCount;
  logic [7:0] delayCount;
  logic [7:0] next_delayCount;
  logic [9:0] sar;
  logic [9:0] next_sar;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_timerOneReset;
  logic next_wakeRequest;
  logic next_acquiring;
  logic next_converterPowered;

  logic wrEn;
  logic rdEn;
  logic rcClock;
  logic goWrite;
  logic goClear;
  logic finish;

  tad_if tad ();

  tad_divider u_tad (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tad(tad)
  );

  assign tad.clockSel = clockSel;
  // the first abort-wait cycle holds the divider so both wait periods are whole
  assign tad.run = (state == ST_CONVERT)
                   || ((state == ST_ABORT_WAIT) && (delayCount != 8'h00));

  // ----------------------------------------------------------------
  // bus decode: one wait state, answer in the access cycle's second edge
  // ----------------------------------------------------------------
  assign wrEn = psel && penable && pwrite && !pready;
  assign rdEn = psel && penable && !pwrite && !pready;
  assign rcClock = (clockSel[1:0] == 2'b11);
  assign goWrite = wrEn && (paddr == `OFF_CONTROL) && pwdata[`BIT_GO]
                   && control[`BIT_ENABLE];
  assign goClear = wrEn && (paddr == `OFF_CONTROL) && !pwdata[`BIT_GO];
  assign finish = (state == ST_CONVERT) && tad.tick && (tadCount == `TAD_PER_CONV - 4'h1);

  // ----------------------------------------------------------------
  // control, results and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_control = control;
    next_resultHigh = resultHigh;
    next_resultLow = resultLow;
    next_clockSel = clockSel;
    next_doneFlag = doneFlag;
    next_sleepOff = sleepOff;
    next_state = state;
    next_tadCount = tadCount;
    next_delayCount = delayCount;
    next_sar = sar;
    next_timerOneReset = 1'b0;
    next_wakeRequest = 1'b0;
    // register writes; busy is owned by the sequencer below
    if (wrEn) begin
      if (paddr == `OFF_CONTROL) begin
        next_control = (pwdata[7:0] & `CONTROL_WMASK & 8'hFD)
                       | (control & 8'h02);
      end else if (paddr == `OFF_CLOCK_SEL) begin
        next_clockSel = pwdata[2:0];
      end else if (paddr == `OFF_SYSTEM) begin
        if (pwdata[0]) begin
          next_doneFlag = 1'b0;
        end
      end
    end
    if (!next_control[`BIT_ENABLE]) begin
      next_sleepOff = 1'b0;
    end
    case (state)
      ST_IDLE, ST_OFF: begin
        if (control[`BIT_ENABLE] && !sleepOff && (goWrite || specialEvent)) begin
          next_control[`BIT_GO] = 1'b1;
          next_timerOneReset = specialEvent;
          next_tadCount = 4'h0;
          next_delayCount = 8'h00;
          next_sar = sampleCode;
          next_state = rcClock ? ST_RC_DELAY : ST_CONVERT;
        end
      end
      ST_RC_DELAY: begin
        next_delayCount = delayCount + 8'h01;
        if (delayCount == `RC_START_DELAY - 8'h01) begin
          next_state = ST_CONVERT;
        end
        if (goClear) begin
          next_control[`BIT_GO] = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_CONVERT: begin
        if (tad.tick) begin
          next_tadCount = tadCount + 4'h1;
        end
        if (goClear) begin
          next_control[`BIT_GO] = 1'b0;
          next_tadCount = 4'h0;
          next_delayCount = 8'h00;
          next_state = ST_ABORT_WAIT;
        end else if (sleepActive && !rcClock) begin
          next_control[`BIT_GO] = 1'b0;
          next_sleepOff = 1'b1;
          next_tadCount = 4'h0;
          next_state = ST_IDLE;
        end else if (finish) begin
          next_control[`BIT_GO] = 1'b0;
          next_doneFlag = 1'b1;
          if (control[`BIT_JUSTIFY]) begin
            next_resultHigh = {6'h00, sar[9:8]};
            next_resultLow = sar[7:0];
          end else begin
            next_resultHigh = sar[9:2];
            next_resultLow = {sar[1:0], 6'h00};
          end
          next_tadCount = 4'h0;
          if (sleepActive) begin
            next_wakeRequest = irqEnable;
            next_sleepOff = !irqEnable;
          end
          next_state = ST_IDLE;
        end
      end
      ST_ABORT_WAIT: begin
        next_delayCount = 8'h01;
        if (tad.tick && (delayCount != 8'h00)) begin
          next_tadCount = tadCount + 4'h1;
          if (tadCount == `TAD_ABORT_WAIT - 4'h1) begin
            next_tadCount = 4'h0;
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a disabled converter ends everything
    if (!next_control[`BIT_ENABLE]) begin
      next_control[`BIT_GO] = 1'b0;
      next_state = ST_OFF;
    end else if (state == ST_OFF && next_state == ST_OFF) begin
      next_state = ST_IDLE;
    end
    // wake from sleep brings the converter back
    if (!sleepActive && sleepOff && !(state == ST_CONVERT)) begin
      next_sleepOff = 1'b0;
    end
  end

  assign next_converterPowered = next_control[`BIT_ENABLE] && !next_sleepOff;
  assign next_acquiring = next_converterPowered && (next_state == ST_IDLE);

  // ----------------------------------------------------------------
  // read data and slave answer
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = prdata;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    if (rdEn) begin
      if (paddr == `OFF_CONTROL) begin
        next_prdata = {24'h000000, control & `CONTROL_WMASK};
      end else if (paddr == `OFF_RESULT_HIGH) begin
        next_prdata = {24'h000000, resultHigh};
      end else if (paddr == `OFF_RESULT_LOW) begin
        next_prdata = {24'h000000, resultLow};
      end else if (paddr == `OFF_CLOCK_SEL) begin
        next_prdata = {29'h0000000, clockSel};
      end else if (paddr == `OFF_SYSTEM) begin
        next_prdata = {30'h0000000, sleepOff, doneFlag};
      end else begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b1;
      end
    end else if (wrEn) begin
      if ((paddr != `OFF_CONTROL) && (paddr != `OFF_CLOCK_SEL)
          && (paddr != `OFF_SYSTEM)) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      control <= `CONTROL_RESET;
      resultHigh <= 8'h00;
      resultLow <= 8'h00;
      clockSel <= `CLOCK_SEL_RESET;
      doneFlag <= 1'b0;
      sleepOff <= 1'b0;
      state <= ST_OFF;
      tadCount <= 4'h0;
      delayCount <= 8'h00;
      sar <= 10'h000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      timerOneReset <= 1'b0;
      wakeRequest <= 1'b0;
      acquiring <= 1'b0;
      converterPowered <= 1'b0;
      channelSelect <= 3'h0;
      referenceSelect <= 1'b0;
    end else begin
      control <= next_control;
      resultHigh <= next_resultHigh;
      resultLow <= next_resultLow;
      clockSel <= next_clockSel;
      doneFlag <= next_doneFlag;
      sleepOff <= next_sleepOff;
      state <= next_state;
      tadCount <= next_tadCount;
      delayCount <= next_delayCount;
      sar <= next_sar;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      timerOneReset <= next_timerOneReset;
      wakeRequest <= next_wakeRequest;
      acquiring <= next_acquiring;
      converterPowered <= next_converterPowered;
      channelSelect <= next_control[`CHAN_HI:`CHAN_LO];
      referenceSelect <= next_control[`BIT_REFSEL];
    end
  end
endmodule : adc_conversion_sequencer

//--- src/adc_seq_defines.svh
// register map, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define OFF_CONTROL 8'h00
`define OFF_RESULT_HIGH 8'h04
`define OFF_RESULT_LOW 8'h08
`define OFF_CLOCK_SEL 8'h0C
`define OFF_SYSTEM 8'h10

`define BIT_ENABLE 0
`define BIT_GO 1
`define BIT_JUSTIFY 7
`define BIT_REFSEL 6
`define CHAN_HI 4
`define CHAN_LO 2

`define CONTROL_RESET 8'h00
`define CLOCK_SEL_RESET 3'h0
`define CONTROL_WMASK 8'hDF

`define TAD_PER_CONV 4'hB
`define TAD_ABORT_WAIT 4'h2
`define RC_START_DELAY 8'h04
`define RC_HALF_DIV 8'h14

`endif

//--- src/adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RC_DELAY = 3'b001,
    ST_CONVERT = 3'b010,
    ST_ABORT_WAIT = 3'b011,
    ST_OFF = 3'b100
  } seq_state_t;
  typedef logic [7:0] byte_t;
endpackage : adc_seq_pkg

//--- src/tad_if.sv
// tick link between the sequencer and its conversion clock divider
`timescale 1ns/10ps
interface tad_if;
  logic run;
  logic [2:0] clockSel;
  logic tick;
  modport master (output run, output clockSel, input tick);
  modport divider (input run, input clockSel, output tick);
endinterface : tad_if

//--- src/tad_divider.sv
// bit period tick generator for every conversion clock selection
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module tad_divider (
  input wire logic clk_sys,
  input wire logic resetn,
  tad_if.divider tad
);
  import adc_seq_pkg::*;

  logic [7:0] count;
  logic [7:0] next_count;
  logic tick;
  logic next_tick;
  logic [7:0] limit;

  // one tad is 2,4,8,16,32,64 system clocks, or 21 system clocks for the internal rc codes
  always_comb begin
    case (tad.clockSel)
      3'h0: limit = 8'h01;
      3'h4: limit = 8'h03;
      3'h1: limit = 8'h07;
      3'h5: limit = 8'h0F;
      3'h2: limit = 8'h1F;
      3'h6: limit = 8'h3F;
      default: limit = `RC_HALF_DIV;
    endcase
  end

  always_comb begin
    next_tick = 1'b0;
    next_count = 8'h00;
    if (tad.run) begin
      if (count >= limit) begin
        next_tick = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tad.tick = tick;
endmodule : tad_divider

//--- dv/adc_seq_chk.sv
// port checker of the conversion sequencer
`timescale 1ns/10ps
module adc_seq_chk (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic specialEvent,
  input wire logic sleepActive,
  input wire logic irqEnable,
  input wire logic converterPowered,
  input wire logic acquiring,
  input wire logic timerOneReset,
  input wire logic wakeRequest,
  input wire logic doneFlag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered in one wait state");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_reset_off: assert property (disable iff (1'b0) !resetn |=> !converterPowered && !doneFlag)
    else $error("reset left converter on");
  chk_done_sticky: assert property ($fell(doneFlag) |-> !$past(resetn)
    || ($past(psel) && $past(penable) && $past(pwrite)))
    else $error("done flag cleared without a write");
  chk_timer_cause: assert property (timerOneReset |-> $past(specialEvent))
    else $error("timer reset without trigger");
  chk_wake_cause: assert property (wakeRequest |-> $past(sleepActive) && $past(irqEnable))
    else $error("wake without sleep and irq enable");
  chk_wake_done: assert property (wakeRequest |-> doneFlag)
    else $error("wake without done flag");
  chk_acq_power: assert property (acquiring |-> converterPowered)
    else $error("acquiring while unpowered");
endmodule : adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk adc_seq_chk_inst (.clk_sys, .resetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .specialEvent, .sleepActive, .irqEnable,
  .converterPowered, .acquiring, .timerOneReset, .wakeRequest, .doneFlag);

//--- dv/tb_top.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/10ps
module tb_top;
  import adc_seq_pkg::*;
  logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, slv, converterPowered, referenceSelect, acquiring;
  logic timerOneReset, wakeRequest, doneFlag, specialEvent = 0, sleepActive = 0;
  logic irqEnable = 0, tmrSeen = 0, wakeSeen = 0;
  logic [9:0] sampleCode = 10'h2B5;
  logic [2:0] channelSelect;
  int err_count = 0, total_checks = 0, n;
  // tick divisor indexed by clock select code
  int divs[8] = '{2, 8, 32, 21, 4, 16, 64, 21};
  adc_conversion_sequencer adc_conversion_sequencer_inst (.clk_sys, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleCode,
    .specialEvent, .sleepActive, .irqEnable, .converterPowered, .channelSelect,
    .referenceSelect, .acquiring, .timerOneReset, .wakeRequest, .doneFlag);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (timerOneReset === 1'b1) tmrSeen <= 1;
    if (wakeRequest === 1'b1) wakeSeen <= 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t no pready", $time);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask : apb
  task automatic go(input int code, input logic [31:0] ctl);
    apb(1, 8'h0C, code);
    apb(1, 8'h00, ctl);
    repeat (8) @(posedge clk_sys);
    apb(1, 8'h00, ctl | 32'h2);
  endtask : go
  task automatic wait_done;
    n = 0;
    while (doneFlag !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(doneFlag, 1);
  endtask : wait_done
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(0, 8'h14, 0);
    chk(slv, 1);
    chk(rd, 0);
    apb(1, 8'h00, 32'hFF);
    apb(0, 8'h00, 0);
    chk(rd, 32'hDD);
    chk({referenceSelect, channelSelect}, 4'hF);
    for (int c = 0; c < 8; c++) begin
      apb(1, 8'h00, c << 2);
      chk(channelSelect, c);
      chk(converterPowered, 0);
    end
    for (int k = 0; k < 8; k++) begin
      go(k, 32'h81);
      apb(0, 8'h00, 0);
      chk(rd, 32'h83);
      wait_done();
      chk(n >= 10 * divs[k] - 6 && n <= 12 * divs[k] + 8, 1);
      apb(0, 8'h00, 0);
      chk(rd, 32'h81);
      apb(0, 8'h04, 0);
      chk(rd, 32'h02);
      apb(0, 8'h08, 0);
      chk(rd, 32'hB5);
      chk(acquiring, 1);
      apb(1, 8'h10, 1);
      chk(doneFlag, 0);
    end
    go(0, 32'h01);
    wait_done();
    apb(1, 8'h04, 32'hFF);
    chk(slv, 1);
    apb(0, 8'h04, 0);
    chk(rd, 32'hAD);
    apb(0, 8'h08, 0);
    chk(rd, 32'h40);
    apb(1, 8'h10, 1);
    sampleCode <= 10'h155;
    go(6, 32'h01);
    repeat (50) @(posedge clk_sys);
    apb(1, 8'h00, 32'h01);
    apb(0, 8'h04, 0);
    chk(rd, 32'hAD);
    chk({doneFlag, acquiring}, 0);
    repeat (136) @(posedge clk_sys);
    chk(acquiring, 1);
    specialEvent <= 1;
    @(posedge clk_sys);
    specialEvent <= 0;
    wait_done();
    chk(tmrSeen, 1);
    apb(0, 8'h04, 0);
    chk(rd, 32'h55);
    apb(1, 8'h10, 1);
    go(6, 32'h01);
    repeat (20) @(posedge clk_sys);
    sleepActive <= 1;
    repeat (4) @(posedge clk_sys);
    chk(converterPowered, 0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h01);
    sleepActive <= 0;
    irqEnable <= 1;
    go(3, 32'h01);
    sleepActive <= 1;
    wait_done();
    @(posedge clk_sys);
    chk(wakeSeen, 1);
    apb(1, 8'h10, 1);
    irqEnable <= 0;
    go(3, 32'h01);
    wait_done();
    repeat (2) @(posedge clk_sys);
    chk(converterPowered, 0);
    apb(0, 8'h00, 0);
    chk(rd, 32'h01);
    sleepActive <= 0;
    go(6, 32'h01);
    repeat (10) @(posedge clk_sys);
    resetn <= 0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1;
    @(posedge clk_sys);
    chk({converterPowered, doneFlag}, 0);
    apb(0, 8'h00, 0);
    chk(rd, 0);
    report_and_stop();
  end
endmodule : tb_top
